//--- core/mcaso_core.sv
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
// Contract
// - zero work op clears work, sets null
// - zero reg op writes 00h, sets null
// - kick clears watchdog, prescaler if assigned
// - kick sets timeout and sleep only
// - invert register, route by destination bit
// - add adjust to decimal, update overflow
// - sub adjust to decimal, flags unchanged
// - minus one, route, update null flag
// - skip variant: no flags, zero discards next
// - jump loads immediate and page bit, two cycles
// - plus one, route, update null flag
module mcaso_core
(
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite register bus
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// decoder side
	input wire logic op_valid,
	output logic op_ready,
	input wire mcaso_pkg::mcaso_op_type op_code,
	input wire logic [5:0] op_reg_index,
	input wire logic op_dest_bit,
	input wire logic [9:0] op_imm,
	input wire logic [7:0] file_operand,
	input wire logic prescaler_on_watchdog,
	// file register, watchdog and program counter side
	output logic file_we,
	output logic [5:0] file_waddr,
	output logic [7:0] file_wdata,
	output logic [7:0] work_register,
	output logic zero_flag,
	output logic carry_flag,
	output logic timeout_flag,
	output logic sleep_flag,
	output logic watchdog_clear,
	output logic prescaler_clear,
	output logic pc_load,
	output logic [10:0] pc_value,
	output logic discard_next
);

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	typedef struct packed
	{
		logic [7:0] work; // work register
		logic zero; // result-null flag
		logic carry; // overflow flag
		logic timeout; // timeout flag
		logic sleep; // sleep flag
		logic [2:0] page; // program page latch
		logic [10:0] pc; // last jump target
		logic stall; // second cycle of a two-cycle op
		logic aw_held; // write address captured
		logic [7:0] aw_addr; // captured write address
		logic w_held; // write data captured
		logic [7:0] w_data; // captured low byte
		logic w_lane0; // low byte lane enabled
		logic bvalid; // write answer pending
		logic [1:0] bresp; // write answer code
		logic rvalid; // read answer pending
		logic [31:0] rdata; // read data
		logic [1:0] rresp; // read answer code
		logic file_we; // file register write strobe
		logic [5:0] file_waddr; // file register index
		logic [7:0] file_wdata; // file register data
		logic watchdog_clr; // watchdog clear pulse
		logic pre_clr; // prescaler clear pulse
		logic pc_load; // program counter load pulse
		logic discard; // drop the fetched instruction
	} mcaso_state_type;

	mcaso_state_type q; // registered state
	mcaso_state_type d; // next state

	logic op_fire; // operation taken this cycle
	logic wr_go; // register write performed this cycle
	logic [7:0] step_result; // invert or step result
	logic step_zero; // step result is zero
	logic [7:0] adj_result; // decimal adjusted work
	logic adj_carry; // adjust overflow

	// --------------------------------------------------------------
	// datapath units
	// --------------------------------------------------------------
	mcaso_step_unit u_step
	(
		.op_code(op_code),
		.operand(file_operand),
		.result(step_result),
		.result_zero(step_zero)
	);

	mcaso_dec_adjust u_adjust
	(
		.work_in(q.work),
		.carry_in(q.carry),
		.subtract(op_code == mcaso_pkg::OP_SUB_ADJUST),
		.work_out(adj_result),
		.carry_out(adj_carry)
	);

	// --------------------------------------------------------------
	// handshakes
	// --------------------------------------------------------------
	// the stall cycle stands in for the discarded or branched fetch
	assign op_ready = !q.stall;
	assign op_fire = op_valid && op_ready;
	assign awready = !q.aw_held;
	assign wready = !q.w_held;
	assign arready = !q.rvalid;
	// an operation owns work and status, so a bus write waits while an operation fires
	assign wr_go = q.aw_held && q.w_held && !q.bvalid && !op_fire;

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb
	begin
		d = q;
		// strobes last one cycle
		d.file_we = 1'b0;
		d.watchdog_clr = 1'b0;
		d.pre_clr = 1'b0;
		d.pc_load = 1'b0;
		d.discard = 1'b0;
		d.stall = 1'b0;
		if (op_fire)
		begin
			case (op_code)
				mcaso_pkg::OP_ZERO_WORK:
				begin
					d.work = mcaso_pkg::ZERO_BYTE;
					d.zero = 1'b1;
				end
				mcaso_pkg::OP_ZERO_REG:
				begin
					d.file_we = 1'b1;
					d.file_waddr = op_reg_index;
					d.file_wdata = mcaso_pkg::ZERO_BYTE;
					d.zero = 1'b1;
				end
				mcaso_pkg::OP_KICK_WATCHDOG:
				begin
					d.watchdog_clr = 1'b1;
					d.pre_clr = prescaler_on_watchdog;
					d.timeout = 1'b1;
					d.sleep = 1'b1;
				end
				mcaso_pkg::OP_INVERT_REG,
				mcaso_pkg::OP_MINUS_ONE,
				mcaso_pkg::OP_PLUS_ONE,
				mcaso_pkg::OP_MINUS_ONE_SKIP:
				begin
					// destination bit 0 keeps the result in work
					if (op_dest_bit)
					begin
						d.file_we = 1'b1;
						d.file_waddr = op_reg_index;
						d.file_wdata = step_result;
					end
					else
					begin
						d.work = step_result;
					end
					if (op_code == mcaso_pkg::OP_MINUS_ONE_SKIP)
					begin
						// flags untouched, zero result drops next fetch
						d.discard = step_zero;
						d.stall = step_zero;
					end
					else
					begin
						d.zero = step_zero;
					end
				end
				mcaso_pkg::OP_ADD_ADJUST:
				begin
					d.work = adj_result;
					d.carry = adj_carry;
				end
				mcaso_pkg::OP_SUB_ADJUST:
				begin
					d.work = adj_result;
				end
				mcaso_pkg::OP_JUMP:
				begin
					d.pc = {q.page[mcaso_pkg::PAGE_PC_BIT], op_imm};
					d.pc_load = 1'b1;
					d.stall = 1'b1;
				end
				default:
				begin
					// no operation: nothing changes
				end
			endcase
		end
		// write channel capture, either order
		if (awvalid && awready)
		begin
			d.aw_held = 1'b1;
			d.aw_addr = awaddr;
		end
		if (wvalid && wready)
		begin
			d.w_held = 1'b1;
			d.w_data = wdata[7:0];
			d.w_lane0 = wstrb[0];
		end
		if (q.bvalid && bready)
		begin
			d.bvalid = 1'b0;
		end
		if (wr_go)
		begin
			d.aw_held = 1'b0;
			d.w_held = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = mcaso_pkg::RESP_OKAY;
			case (q.aw_addr)
				mcaso_pkg::WORK_OFS:
				begin
					if (q.w_lane0)
					begin
						d.work = q.w_data;
					end
				end
				mcaso_pkg::STATUS_OFS:
				begin
					if (q.w_lane0)
					begin
						d.zero = q.w_data[mcaso_pkg::ZERO_BIT];
						d.carry = q.w_data[mcaso_pkg::CARRY_BIT];
						d.sleep = q.w_data[mcaso_pkg::SLEEP_BIT];
						d.timeout = q.w_data[mcaso_pkg::TIMEOUT_BIT];
					end
				end
				mcaso_pkg::PAGE_OFS:
				begin
					if (q.w_lane0)
					begin
						d.page = q.w_data[2:0];
					end
				end
				mcaso_pkg::PC_OFS:
				begin
					// read-only, write is ignored but answered
				end
				default: d.bresp = mcaso_pkg::RESP_SLVERR;
			endcase
		end
		// read channel, one outstanding
		if (q.rvalid && rready)
		begin
			d.rvalid = 1'b0;
		end
		if (arvalid && arready)
		begin
			d.rvalid = 1'b1;
			d.rresp = mcaso_pkg::RESP_OKAY;
			d.rdata = 32'h0000_0000;
			case (araddr)
				mcaso_pkg::WORK_OFS: d.rdata[7:0] = q.work;
				mcaso_pkg::STATUS_OFS:
				begin
					d.rdata[mcaso_pkg::ZERO_BIT] = q.zero;
					d.rdata[mcaso_pkg::CARRY_BIT] = q.carry;
					d.rdata[mcaso_pkg::SLEEP_BIT] = q.sleep;
					d.rdata[mcaso_pkg::TIMEOUT_BIT] = q.timeout;
				end
				mcaso_pkg::PAGE_OFS: d.rdata[2:0] = q.page;
				mcaso_pkg::PC_OFS: d.rdata[10:0] = q.pc;
				default: d.rresp = mcaso_pkg::RESP_SLVERR;
			endcase
		end
	end

	// --------------------------------------------------------------
	// state register
	// --------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q <= '0;
			q.work <= mcaso_pkg::WORK_RST;
			q.zero <= mcaso_pkg::ZERO_RST;
			q.carry <= mcaso_pkg::CARRY_RST;
			q.timeout <= mcaso_pkg::TIMEOUT_RST;
			q.sleep <= mcaso_pkg::SLEEP_RST;
			q.page <= mcaso_pkg::PAGE_RST;
			q.pc <= mcaso_pkg::PC_RST;
		end
		else
		begin
			q <= d;
		end
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign rvalid = q.rvalid;
	assign rdata = q.rdata;
	assign rresp = q.rresp;
	assign file_we = q.file_we;
	assign file_waddr = q.file_waddr;
	assign file_wdata = q.file_wdata;
	assign work_register = q.work;
	assign zero_flag = q.zero;
	assign carry_flag = q.carry;
	assign timeout_flag = q.timeout;
	assign sleep_flag = q.sleep;
	assign watchdog_clear = q.watchdog_clr;
	assign prescaler_clear = q.pre_clr;
	assign pc_load = q.pc_load;
	assign pc_value = q.pc;
	assign discard_next = q.discard;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// taken skip: drop pulse with stall, then ready again
	sequence skip_taken_s;
		discard_next && !op_ready ##1 op_ready && !discard_next;
	endsequence

	// jump: load pulse with stall, then ready again
	sequence jump_taken_s;
		pc_load && !op_ready ##1 op_ready && !pc_load;
	endsequence

	zero_work_a: assert property (
		op_fire && op_code == mcaso_pkg::OP_ZERO_WORK
		|=> work_register == 8'h00 && zero_flag)
		else $error("work not cleared");

	zero_reg_a: assert property (
		op_fire && op_code == mcaso_pkg::OP_ZERO_REG
		|=> file_we && file_wdata == 8'h00 && zero_flag
		&& file_waddr == $past(op_reg_index))
		else $error("register not cleared");

	kick_clear_a: assert property (
		op_fire && op_code == mcaso_pkg::OP_KICK_WATCHDOG
		|=> watchdog_clear
		&& prescaler_clear == $past(prescaler_on_watchdog))
		else $error("watchdog clear wrong");

	kick_flags_a: assert property (
		op_fire && op_code == mcaso_pkg::OP_KICK_WATCHDOG
		|=> timeout_flag && sleep_flag && $stable(zero_flag)
		&& $stable(carry_flag))
		else $error("kick flags wrong");

	invert_route_a: assert property (
		op_fire && op_code == mcaso_pkg::OP_INVERT_REG && !op_dest_bit
		|=> work_register == ~$past(file_operand) && !file_we)
		else $error("invert result wrong");

	add_adjust_a: assert property (
		op_fire && op_code == mcaso_pkg::OP_ADD_ADJUST
		&& work_register > 8'h99
		|=> carry_flag && work_register == $past(work_register) + 8'h60
		+ ($past(work_register[3:0]) > 4'h9 ? 8'h06 : 8'h00))
		else $error("add adjust wrong");

	sub_adjust_a: assert property (
		op_fire && op_code == mcaso_pkg::OP_SUB_ADJUST
		|=> $stable(zero_flag) && $stable(carry_flag)
		&& $stable(timeout_flag) && $stable(sleep_flag))
		else $error("sub adjust touched flags");

	minus_one_a: assert property (
		op_fire && op_code == mcaso_pkg::OP_MINUS_ONE && op_dest_bit
		|=> file_we && file_wdata == $past(file_operand) - 8'h01
		&& zero_flag == ($past(file_operand) == 8'h01))
		else $error("minus one wrong");

	skip_zero_a: assert property (
		op_fire && op_code == mcaso_pkg::OP_MINUS_ONE_SKIP
		&& file_operand == 8'h01
		|=> skip_taken_s and $stable(zero_flag))
		else $error("skip not taken");

	no_skip_a: assert property (
		op_fire && op_code == mcaso_pkg::OP_MINUS_ONE_SKIP
		&& file_operand != 8'h01
		|=> !discard_next && op_ready)
		else $error("skip taken wrongly");

	jump_load_a: assert property (
		op_fire && op_code == mcaso_pkg::OP_JUMP
		|=> pc_value == {$past(q.page[2]), $past(op_imm)}
		&& $stable(zero_flag) ##0 jump_taken_s)
		else $error("jump wrong");

	plus_one_a: assert property (
		op_fire && op_code == mcaso_pkg::OP_PLUS_ONE && !op_dest_bit
		|=> work_register == $past(file_operand) + 8'h01
		&& zero_flag == ($past(file_operand) == 8'hFF))
		else $error("plus one wrong");

endmodule

//--- core/mcaso_dec_adjust.sv
`timescale 1ns/1ps
// packed decimal correction of the work register
module mcaso_dec_adjust
(
	input wire logic [7:0] work_in,
	input wire logic carry_in,
	input wire logic subtract,
	output logic [7:0] work_out,
	output logic carry_out
);

	logic low_fix; // low digit out of decimal range
	logic high_fix; // high fix: subtract judges the high digit, add a prior carry or a byte past 99

	// --------------------------------------------------------------
	// correction terms
	// --------------------------------------------------------------
	// no half carry exists here, so the low digit is judged by value
	always_comb
	begin
		low_fix = (work_in[3:0] > mcaso_pkg::NIBBLE_LIMIT);
		if (subtract)
		begin
			high_fix = (work_in[7:4] > mcaso_pkg::NIBBLE_LIMIT);
			work_out = work_in
				- (low_fix ? mcaso_pkg::LOW_FIX : mcaso_pkg::ZERO_BYTE)
				- (high_fix ? mcaso_pkg::HIGH_FIX : mcaso_pkg::ZERO_BYTE);
		end
		else
		begin
			// a prior carry or a value past 99 needs the high fix
			high_fix = carry_in || (work_in > mcaso_pkg::BYTE_LIMIT);
			work_out = work_in
				+ (low_fix ? mcaso_pkg::LOW_FIX : mcaso_pkg::ZERO_BYTE)
				+ (high_fix ? mcaso_pkg::HIGH_FIX : mcaso_pkg::ZERO_BYTE);
		end
		carry_out = high_fix;
	end

endmodule

//--- core/mcaso_step_unit.sv
`timescale 1ns/1ps
// combinational step logic for the file-register operations
module mcaso_step_unit
(
	input wire mcaso_pkg::mcaso_op_type op_code,
	input wire logic [7:0] operand,
	output logic [7:0] result,
	output logic result_zero
);

	// --------------------------------------------------------------
	// result select
	// --------------------------------------------------------------
	// one shared path for invert, plus one and both minus one forms
	always_comb
	begin
		case (op_code)
			mcaso_pkg::OP_INVERT_REG: result = ~operand;
			mcaso_pkg::OP_PLUS_ONE: result = operand + mcaso_pkg::ONE_BYTE;
			mcaso_pkg::OP_MINUS_ONE,
			mcaso_pkg::OP_MINUS_ONE_SKIP:
				result = operand - mcaso_pkg::ONE_BYTE;
			default: result = mcaso_pkg::ZERO_BYTE;
		endcase
	end

	// zero test on the full 8-bit result
	assign result_zero = (result == mcaso_pkg::ZERO_BYTE);

endmodule

//--- dv/mcaso_file_model.sv
`timescale 1ns/1ps
// --------------------------------------------------------------
// file register array seen by the step logic
// --------------------------------------------------------------
// the decoder reads the selected register in the same cycle, so the
// operand is a plain combinational read of the array
module mcaso_file_model
(
	input wire logic aclk,
	input wire logic file_we,
	input wire logic [5:0] file_waddr,
	input wire logic [7:0] file_wdata,
	input wire logic [5:0] rd_index,
	input wire logic pre_we,
	input wire logic [5:0] pre_idx,
	input wire logic [7:0] pre_val,
	output logic [7:0] rd_data
);
	// sixty-four registers, index 0 to 63
	logic [7:0] mem_q [64];

	// bench preload wins over a design write in the same cycle
	always_ff @(posedge aclk)
	begin
		if (pre_we)
			mem_q[pre_idx] <= pre_val;
		else if (file_we)
			mem_q[file_waddr] <= file_wdata;
	end

	// operand of the selected register
	assign rd_data = mem_q[rd_index];
endmodule

//--- dv/mcu_clear_adjust_step_ops_tb.sv
`timescale 1ns/1ps
module mcu_clear_adjust_step_ops_tb;
	// --------------------------------------------------------------
	// stimulus and observed signals
	// --------------------------------------------------------------
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, pre_val = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, pre_we = 1'b0;
	logic op_valid = 1'b0, op_dest_bit = 1'b0, prescaler_on_watchdog = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	mcaso_pkg::mcaso_op_type op_code = mcaso_pkg::OP_NONE;
	logic [5:0] op_reg_index = 6'h00, pre_idx = 6'h00;
	logic [9:0] op_imm = 10'h000;
	logic [7:0] file_operand, file_wdata, work_register;
	logic awready, wready, bvalid, arready, rvalid, op_ready, file_we;
	logic zero_flag, carry_flag, timeout_flag, sleep_flag, pc_load;
	logic watchdog_clear, prescaler_clear, discard_next;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [5:0] file_waddr;
	logic [10:0] pc_value;
	int errors = 0;
	int n_compared = 0;

	mcaso_core dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .op_valid,
		.op_ready, .op_code, .op_reg_index, .op_dest_bit, .op_imm,
		.file_operand, .prescaler_on_watchdog, .file_we, .file_waddr,
		.file_wdata, .work_register, .zero_flag, .carry_flag, .timeout_flag,
		.sleep_flag, .watchdog_clear, .prescaler_clear, .pc_load, .pc_value,
		.discard_next);

	mcaso_file_model model (.aclk, .file_we, .file_waddr, .file_wdata,
		.rd_index(op_reg_index), .pre_we, .pre_idx, .pre_val,
		.rd_data(file_operand));

	// free-running 100 MHz clock
	initial
	begin
		forever #5 aclk = ~aclk;
	end

	// --------------------------------------------------------------
	// shared checking and bus tasks
	// --------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// address and data offered together, each dropped once taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		int i;
		logic aw_p, w_p, b_p, aw_t, w_t, b_t;
		aw_p = 1'b1;
		w_p = 1'b1;
		b_p = 1'b1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 50 && (aw_p || w_p || b_p); i++)
		begin
			// ready lines settle well before the next edge
			@(negedge aclk);
			aw_t = aw_p && awready;
			w_t = w_p && wready;
			b_t = b_p && bvalid;
			if (b_t)
				check("bresp", bresp, mcaso_pkg::RESP_OKAY);
			@(posedge aclk);
			if (aw_t)
				awvalid <= 1'b0;
			if (w_t)
				wvalid <= 1'b0;
			if (b_t)
				bready <= 1'b0;
			aw_p = aw_p && !aw_t;
			w_p = w_p && !w_t;
			b_p = b_p && !b_t;
		end
		if (i == 50)
		begin
			errors++;
			results();
		end
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int i;
		logic a_t, r_t;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(negedge aclk);
			a_t = arvalid && arready;
			r_t = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (a_t)
				arvalid <= 1'b0;
			if (r_t)
			begin
				rready <= 1'b0;
				break;
			end
		end
		if (i == 50)
		begin
			errors++;
			results();
		end
	endtask

	// one decoder request; returns in the cycle that shows its effects
	task automatic do_op(input mcaso_pkg::mcaso_op_type c,
		input logic [5:0] x, input logic dst, input logic [9:0] m,
		input logic p);
		int i;
		@(posedge aclk);
		op_valid <= 1'b1;
		op_code <= c;
		op_reg_index <= x;
		op_dest_bit <= dst;
		op_imm <= m;
		prescaler_on_watchdog <= p;
		for (i = 0; i < 50; i++)
		begin
			@(negedge aclk);
			if (op_ready === 1'b1)
				break;
		end
		if (i == 50)
		begin
			errors++;
			results();
		end
		@(posedge aclk);
		op_valid <= 1'b0;
		#1;
	endtask

	task automatic preload(input logic [5:0] x, input logic [7:0] v);
		@(posedge aclk);
		pre_we <= 1'b1;
		pre_idx <= x;
		pre_val <= v;
		@(posedge aclk);
		pre_we <= 1'b0;
	endtask

	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	task automatic reset_scn;
		logic [31:0] d;
		logic [1:0] r;
		axi_read(mcaso_pkg::STATUS_OFS, d, r);
		check("status at reset", d, 32'h18);
		axi_read(8'h40, d, r);
		check("unmapped resp", r, mcaso_pkg::RESP_SLVERR);
		check("unmapped data", d, 32'h0);
		// read-only target and a disabled low lane must leave state alone
		axi_write(mcaso_pkg::PC_OFS, 32'h7FF);
		wstrb <= 4'hE;
		axi_write(mcaso_pkg::WORK_OFS, 32'hFF);
		wstrb <= 4'hF;
		axi_read(mcaso_pkg::PC_OFS, d, r);
		check("pc read only", d, 32'h0);
		axi_read(mcaso_pkg::WORK_OFS, d, r);
		check("lane off", d, 32'h0);
		check("read resp", r, mcaso_pkg::RESP_OKAY);
	endtask

	task automatic clear_scn;
		axi_write(mcaso_pkg::WORK_OFS, 32'h5A);
		axi_write(mcaso_pkg::STATUS_OFS, 32'h0);
		do_op(mcaso_pkg::OP_ZERO_WORK, 6'h00, 1'b0, 10'h000, 1'b0);
		check("work", work_register, 32'h0);
		check("zero", zero_flag, 32'h1);
		axi_write(mcaso_pkg::STATUS_OFS, 32'h0);
		preload(6'h3F, 8'hAA);
		do_op(mcaso_pkg::OP_ZERO_REG, 6'h3F, 1'b0, 10'h000, 1'b0);
		check("file_we", file_we, 32'h1);
		check("file_waddr", file_waddr, 32'h3F);
		check("file_wdata", file_wdata, 32'h0);
		check("zero", zero_flag, 32'h1);
	endtask

	// complement and steps, both destinations, zero and nonzero results
	task automatic step_scn;
		mcaso_pkg::mcaso_op_type c [6] = '{mcaso_pkg::OP_INVERT_REG,
			mcaso_pkg::OP_INVERT_REG, mcaso_pkg::OP_PLUS_ONE,
			mcaso_pkg::OP_PLUS_ONE, mcaso_pkg::OP_MINUS_ONE,
			mcaso_pkg::OP_MINUS_ONE};
		logic [7:0] v [6] = '{8'hFF, 8'h0F, 8'hFF, 8'h41, 8'h01, 8'h00};
		logic [7:0] e [6] = '{8'h00, 8'hF0, 8'h00, 8'h42, 8'h00, 8'hFF};
		logic dd [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
		for (int k = 0; k < 6; k++)
		begin
			preload(6'(k), v[k]);
			axi_write(mcaso_pkg::WORK_OFS, 32'h33);
			do_op(c[k], 6'(k), dd[k], 10'h000, 1'b0);
			check("zero", zero_flag, e[k] == 8'h00);
			check("file_we", file_we, dd[k]);
			if (dd[k])
			begin
				check("file_wdata", file_wdata, e[k]);
				check("file_waddr", file_waddr, k);
				check("work kept", work_register, 32'h33);
			end
			else
				check("work", work_register, e[k]);
		end
	endtask

	// prescaler cleared only when it belongs to the watchdog
	task automatic kick_scn;
		for (int p = 0; p < 2; p++)
		begin
			axi_write(mcaso_pkg::STATUS_OFS, 32'h03);
			do_op(mcaso_pkg::OP_KICK_WATCHDOG, 6'h00, 1'b0, 10'h000, p[0]);
			check("watchdog_clear", watchdog_clear, 32'h1);
			check("prescaler_clear", prescaler_clear, p);
			check("timeout", timeout_flag, 32'h1);
			check("sleep", sleep_flag, 32'h1);
			check("zero kept", zero_flag, 32'h1);
			check("carry kept", carry_flag, 32'h1);
		end
	endtask

	// first four add cases, last three subtract cases
	task automatic adjust_scn;
		logic [7:0] vi [7] = '{8'h0F, 8'h9A, 8'h12, 8'h45, 8'h0F, 8'hA5, 8'hFA};
		logic [7:0] vo [7] = '{8'h15, 8'h00, 8'h72, 8'h45, 8'h09, 8'h45, 8'h94};
		logic ci [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
		logic co [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
		logic [31:0] d;
		logic [1:0] r;
		for (int k = 0; k < 7; k++)
		begin
			axi_write(mcaso_pkg::STATUS_OFS, k < 4 ? {30'h0, ci[k], 1'b0}
				: 32'h1B);
			axi_write(mcaso_pkg::WORK_OFS, vi[k]);
			do_op(k < 4 ? mcaso_pkg::OP_ADD_ADJUST : mcaso_pkg::OP_SUB_ADJUST,
				6'h00, 1'b0, 10'h000, 1'b0);
			check("work", work_register, vo[k]);
			if (k < 4)
				check("carry", carry_flag, co[k]);
			else
			begin
				axi_read(mcaso_pkg::STATUS_OFS, d, r);
				check("status kept", d, 32'h1B);
			end
		end
	endtask

	task automatic skip_scn;
		axi_write(mcaso_pkg::STATUS_OFS, 32'h01);
		preload(6'h05, 8'h02);
		do_op(mcaso_pkg::OP_MINUS_ONE_SKIP, 6'h05, 1'b1, 10'h000, 1'b0);
		check("file_wdata", file_wdata, 32'h01);
		check("file_we", file_we, 32'h1);
		check("discard", discard_next, 32'h0);
		check("zero kept", zero_flag, 32'h1);
		check("op_ready", op_ready, 32'h1);
		axi_write(mcaso_pkg::STATUS_OFS, 32'h0);
		preload(6'h06, 8'h01);
		do_op(mcaso_pkg::OP_MINUS_ONE_SKIP, 6'h06, 1'b0, 10'h000, 1'b0);
		check("work", work_register, 32'h0);
		check("discard", discard_next, 32'h1);
		check("zero kept", zero_flag, 32'h0);
		check("op_ready", op_ready, 32'h0);
		@(posedge aclk);
		#1;
		check("op_ready after", op_ready, 32'h1);
		check("discard after", discard_next, 32'h0);
	endtask

	task automatic jump_scn;
		logic [31:0] d;
		logic [1:0] r;
		axi_write(mcaso_pkg::STATUS_OFS, 32'h03);
		axi_write(mcaso_pkg::PAGE_OFS, 32'h4);
		do_op(mcaso_pkg::OP_JUMP, 6'h00, 1'b0, 10'h2A5, 1'b0);
		check("pc_load", pc_load, 32'h1);
		check("pc_value", pc_value, 32'h6A5);
		check("op_ready", op_ready, 32'h0);
		check("flags kept", {zero_flag, carry_flag}, 32'h3);
		@(posedge aclk);
		#1;
		check("op_ready after", op_ready, 32'h1);
		axi_write(mcaso_pkg::PAGE_OFS, 32'h3);
		do_op(mcaso_pkg::OP_JUMP, 6'h00, 1'b0, 10'h3FF, 1'b0);
		check("pc_value", pc_value, 32'h3FF);
		axi_read(mcaso_pkg::PC_OFS, d, r);
		check("pc register", d, 32'h3FF);
	endtask

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		reset_scn();
		clear_scn();
		step_scn();
		kick_scn();
		adjust_scn();
		skip_scn();
		jump_scn();
		results();
	end
endmodule

//--- include/mcaso_pkg.sv
package mcaso_pkg;

	// --------------------------------------------------------------
	// data and register constants
	// --------------------------------------------------------------
	localparam logic [7:0] ZERO_BYTE = 8'h00; // cleared value
	localparam logic [7:0] ONE_BYTE = 8'h01; // step amount
	localparam logic [7:0] WORK_RST = 8'h00; // work register at reset
	localparam logic [2:0] PAGE_RST = 3'h0; // page latch at reset
	localparam logic [10:0] PC_RST = 11'h000; // jump target at reset
	localparam logic ZERO_RST = 1'b0; // result-null flag at reset
	localparam logic CARRY_RST = 1'b0; // overflow flag at reset
	localparam logic TIMEOUT_RST = 1'b1; // timeout flag at reset
	localparam logic SLEEP_RST = 1'b1; // sleep flag at reset
	localparam int PAGE_PC_BIT = 2; // latch bit copied to pc bit 10

	// --------------------------------------------------------------
	// decimal adjust constants
	// --------------------------------------------------------------
	localparam logic [3:0] NIBBLE_LIMIT = 4'h9; // largest decimal digit
	localparam logic [7:0] BYTE_LIMIT = 8'h99; // largest decimal byte
	localparam logic [7:0] LOW_FIX = 8'h06; // low digit correction
	localparam logic [7:0] HIGH_FIX = 8'h60; // high digit correction

	// --------------------------------------------------------------
	// register map, byte addresses
	// --------------------------------------------------------------
	localparam logic [7:0] WORK_OFS = 8'h00; // work register, rw
	localparam logic [7:0] STATUS_OFS = 8'h04; // status flags, rw
	localparam logic [7:0] PAGE_OFS = 8'h08; // page latch, rw
	localparam logic [7:0] PC_OFS = 8'h0C; // last jump target, ro
	localparam int ZERO_BIT = 0; // status: result-null
	localparam int CARRY_BIT = 1; // status: overflow
	localparam int SLEEP_BIT = 3; // status: sleep
	localparam int TIMEOUT_BIT = 4; // status: timeout
	localparam logic [1:0] RESP_OKAY = 2'h0; // bus answer ok
	localparam logic [1:0] RESP_SLVERR = 2'h2; // unmapped address

	// --------------------------------------------------------------
	// operation codes from the decoder
	// --------------------------------------------------------------
	typedef enum logic [3:0]
	{
		OP_NONE = 4'h0,
		OP_ZERO_WORK = 4'h1,
		OP_ZERO_REG = 4'h2,
		OP_KICK_WATCHDOG = 4'h3,
		OP_INVERT_REG = 4'h4,
		OP_ADD_ADJUST = 4'h5,
		OP_SUB_ADJUST = 4'h6,
		OP_MINUS_ONE = 4'h7,
		OP_MINUS_ONE_SKIP = 4'h8,
		OP_JUMP = 4'h9,
		OP_PLUS_ONE = 4'hA
	} mcaso_op_type;

endpackage
